// file: fbrm_conv.sv
// Format converter between database values and 16-bit bus registers.
// Assumes floats arrive as signed fixed point with 8 fraction bits.
`timescale 1ns/10ps
`include "fbrm_map.svh"
module fbrm_conv (
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire fbrm_pkg::fbrm_fmt_type fmt_i,
  input  wire logic [3:0]           decimal_point_field_i,
  input  wire logic [31:0]          db_val_i,
  input  wire logic [15:0]          reg_val_i,
  output logic      [15:0]          to_reg_o,
  output logic      [31:0]          to_db_o
);
  logic signed [47:0] scaled;   // Outbound float times power of ten
  logic signed [47:0] rounded;  // Integer after rounding
  logic signed [47:0] clamped;  // Limited to documented range
  logic signed [47:0] in_scl;   // Inbound float fixed point

  // Power of ten for a decimal point setting
  function automatic logic [31:0] pow10(input logic [3:0] dp);
    logic [31:0] p;
    p = 32'h1;
    for (int k = 0; k < 9; k++) begin
      if (k < dp) begin
        p = p * 32'hA;
      end
    end
    return p;
  endfunction : pow10

  // Scale, round and clamp for outbound floats
  always_comb begin
    // (RULE5) scale round clamp
    scaled  = $signed({{16{db_val_i[31]}}, db_val_i}) *
              $signed({16'h0000, pow10(decimal_point_field_i)});
    rounded = (scaled + 48'sh80) >>> 8;
    if (rounded < `FBRM_FLT_MIN) begin
      clamped = `FBRM_FLT_MIN;
    end else if (rounded > `FBRM_FLT_MAX) begin
      clamped = `FBRM_FLT_MAX;
    end else begin
      clamped = rounded;
    end
    // (RULE6) signed then scaled
    in_scl = ($signed({{32{reg_val_i[15]}}, reg_val_i}) <<< 8) /
             $signed({16'h0000, pow10(decimal_point_field_i)});
  end

  // Registered results
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      to_reg_o <= 16'h0000;
      to_db_o  <= 32'h0000_0000;
    end else begin
      case (fmt_i)
        fbrm_pkg::FBRM_FMT_SLONG: begin
          // (RULE2) low half out
          to_reg_o <= db_val_i[15:0];
          // (RULE3) sign extend in
          to_db_o  <= {{16{reg_val_i[15]}}, reg_val_i};
        end
        fbrm_pkg::FBRM_FMT_ULONG: begin
          // (RULE4) zero high half
          to_reg_o <= db_val_i[15:0];
          to_db_o  <= {16'h0000, reg_val_i};
        end
        fbrm_pkg::FBRM_FMT_FLOAT: begin
          to_reg_o <= clamped[15:0];
          to_db_o  <= in_scl[31:0];
        end
        default: begin
          // (RULE1) pass unchanged
          to_reg_o <= db_val_i[15:0];
          to_db_o  <= {16'h0000, reg_val_i};
        end
      endcase
    end
  end
endmodule : fbrm_conv

// file: fbrm_far_model.sv
// Far-side instrument: raises one link event per call.
// Assumes the caller owns the clock; drives at the falling edge.
`timescale 1ns/10ps
module fbrm_far_model (
  input  wire logic        clk_sys_i,
  output logic      [13:0] ev_o,
  output logic             wr_o,
  output logic      [3:0]  tbl_o,
  output logic      [15:0] dat_o,
  output logic      [3:0]  code_o
);
  initial begin
    ev_o = '0;
    wr_o = 1'b0;
    tbl_o = 4'h0;
    dat_o = 16'h0000;
    code_o = 4'h0;
  end
  // One-cycle event; data lines scrambled once released
  task automatic ev(input int k, input logic [3:0] t, input logic [15:0] d,
                    input logic [3:0] c, input logic w);
    @(negedge clk_sys_i);
    ev_o[k] = 1'b1;
    tbl_o = t;
    dat_o = d;
    code_o = c;
    wr_o = w;
    @(negedge clk_sys_i);
    ev_o = '0;
    dat_o = ~d;
  endtask : ev
endmodule : fbrm_far_model

// file: fbrm_map.svh
// Offsets, field positions, reset values and timing counts for the
// fieldbus register map and diagnostic table. Included by the converter, register map and table memory.
// Contract
// (RULE1) Values up to 16 bits pass unchanged
// (RULE2) Signed 32-bit outbound keeps low half
// (RULE3) Inbound signed 32-bit is sign extended
// (RULE4) Unsigned: inbound zero high, outbound low half
// (RULE5) Float out: scale, round, clamp, cut
// (RULE6) Float in: signed register, then scaled
// (RULE7) Double pair at even address, coherent
// (RULE8) Table of 32: 0-15 internal, 16-31 tables
// (RULE9) Internal registers read-only, mode independent
// (RULE10) Offset 2 bit 5 shows listen-only
// (RULE11) Offset 3 echo data, 4 delimiter
// (RULE12) Offset 7 counts sent exceptions
// (RULE13) Offsets 11-14 timings in 4 ms ticks
// (RULE14) Address 16+n serves table n+1
// (RULE15) Slave write-disable refuses with exception 8
// (RULE16) Slave online while accessed within timeout
// (RULE17) Master write error code else zero
// (RULE18) Master read error code else zero
// (RULE19) Master write-disable stops; clearing forces writes
// (RULE20) Scan-completed sets at end, clears on single-scan
// (RULE21) One-shot poll handshake with continuous disabled
// (RULE22) Continuous-scan disable stops polling; online flag
// (RULE23) Error codes in bits 8-B or C-F
// (RULE24) Flag bit positions chosen here
`ifndef FBRM_MAP_SVH
`define FBRM_MAP_SVH

// Internal diagnostic offsets
`define FBRM_OFS_LISTEN_STATE 5'h02
`define FBRM_OFS_ECHO_QUERY   5'h03
`define FBRM_OFS_IN_DELIM     5'h04
`define FBRM_OFS_ERR_COUNT    5'h07
`define FBRM_OFS_POLL_PERIOD  5'h0B
`define FBRM_OFS_CHECK_TIME   5'h0C
`define FBRM_OFS_LAST_SCAN    5'h0D
`define FBRM_OFS_LAST_DELAY   5'h0E
`define FBRM_OFS_TABLE_BASE   5'h10
// Listen-only bit inside offset 2
`define FBRM_BIT_LISTEN       5
// Per-table flag positions
`define FBRM_BIT_WR_DIS       0
`define FBRM_BIT_ONLINE       1
`define FBRM_BIT_SINGLE       2
`define FBRM_BIT_DONE         3
`define FBRM_BIT_NO_CONT      4
`define FBRM_RERR_LSB         8
`define FBRM_WERR_LSB         12
// Exception returned on refused slave write
`define FBRM_EXC_WRITE        4'h8
// Reset value of a table register
`define FBRM_TBL_RESET        16'h0000
// Tick length 4 ms at 40 MHz
`define FBRM_TICK_MS          4
`define FBRM_CLK_KHZ          40000
`define FBRM_TICK_CYCLES      (`FBRM_TICK_MS * `FBRM_CLK_KHZ)
// Float clamp limits
`define FBRM_FLT_MIN          (-48'sd65536)
`define FBRM_FLT_MAX          48'sd65535

`endif

// file: fbrm_pkg.sv
// Types shared by the register map and its helpers.
// Assumes the map header supplies all numbers.
package fbrm_pkg;
  // Database value formats
  typedef enum logic [2:0] {
    FBRM_FMT_SHORT,
    FBRM_FMT_SLONG,
    FBRM_FMT_ULONG,
    FBRM_FMT_FLOAT,
    FBRM_FMT_DOUBLE
  } fbrm_fmt_type;
  // Scan engine states
  typedef enum logic [1:0] {
    FBRM_SC_IDLE,
    FBRM_SC_BUSY,
    FBRM_SC_DONE
  } fbrm_scan_type;
endpackage : fbrm_pkg

// file: fbrm_register_map.sv
// Diagnostic table and register mapping for the fieldbus gateway.
// Assumes one clock; bus events from the link engine are same-clock
// pulses, database port is a simple read/write strobe interface.
`timescale 1ns/10ps
`include "fbrm_map.svh"
module fbrm_register_map (
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   master_mode_i,
  // Database side diagnostic access
  input  wire logic                   db_wr_i,
  input  wire logic                   db_rd_i,
  input  wire logic [4:0]             db_addr_i,
  input  wire logic [15:0]            db_wdata_i,
  output logic      [15:0]            db_rdata_o,
  output logic                        db_rvalid_o,
  // Value conversion path
  input  wire fbrm_pkg::fbrm_fmt_type fmt_i,
  input  wire logic [3:0]             decimal_point_field_i,
  input  wire logic [31:0]            db_val_i,
  input  wire logic [15:0]            reg_val_i,
  output logic      [15:0]            to_reg_o,
  output logic      [31:0]            to_db_o,
  // Double precision pair transfer
  input  wire logic                   pair_ld_i,
  input  wire logic [15:0]            pair_addr_i,
  output logic      [31:0]            pair_val_o,
  output logic                        pair_err_o,
  // Link events (slave)
  input  wire logic                   ev_echo_i,
  input  wire logic                   ev_delim_i,
  input  wire logic [15:0]            ev_data_i,
  input  wire logic                   ev_listen_i,
  input  wire logic                   ev_restart_i,
  input  wire logic                   ev_exc_sent_i,
  input  wire logic                   ev_access_i,
  input  wire logic                   ev_access_wr_i,
  input  wire logic [3:0]             ev_table_i,
  input  wire logic [15:0]            timeout_ticks_i,
  output logic                        wr_refuse_o,
  output logic [3:0]                  exc_code_o,
  // Link events (master)
  input  wire logic                   ev_scan_end_i,
  input  wire logic                   ev_rd_err_i,
  input  wire logic                   ev_wr_done_i,
  input  wire logic [3:0]             ev_err_code_i,
  input  wire logic                   ev_answer_i,
  output logic [15:0]                 poll_en_o,
  output logic [15:0]                 write_en_o,
  output logic [15:0]                 force_write_o,
  // Task timing inputs in cycles of tick
  input  wire logic                   poll_cycle_i,
  input  wire logic                   scan_start_i,
  input  wire logic                   scan_stop_i,
  input  wire logic                   delay_stop_i
);
  logic [15:0] listen_state_diag;       // Listen-only status
  logic [15:0] echo_query_data;         // Last echo data
  logic [15:0] input_delimiter_value;   // Last delimiter
  logic [15:0] sent_error_count;        // Exceptions sent
  logic [15:0] poll_cycle_period;       // Poll cycle ticks
  logic [15:0] table_check_time;        // Full table scan ticks
  logic [15:0] last_scan_time;          // Last scheduled scan ticks
  logic [15:0] last_delay_time;         // Last delay ticks
  logic [17:0] tick_div;                // Divider for 4 ms tick
  logic        tick;                    // One cycle per 4 ms
  logic [15:0] poll_cnt;                // Running poll ticks
  logic [15:0] scan_cnt;                // Running scan ticks
  logic [15:0] delay_cnt;               // Running delay ticks
  logic [15:0] idle_cnt [16];           // Per-table idle ticks
  logic [15:0] tbl_flags [16];          // Hardware view of tables
  logic [15:0] tbl_rd;                  // Memory read word
  logic        mem_wr;                  // Memory write strobe
  logic [15:0] mem_wdata;               // Memory write word
  logic        rd_pend;                 // Read in flight
  logic        rd_tbl;                  // Read targets tables
  logic [15:0] rd_int;                  // Captured internal word
  logic [3:0]  rd_idx;                  // Table index of read
  logic [15:0] pair_lo;                 // Latched low half

  // Sixteen-bit increment that saturates
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  // Internal register read decode
  function automatic logic [15:0] int_word(input logic [4:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a == `FBRM_OFS_LISTEN_STATE) begin
      w = listen_state_diag;
    end else if (a == `FBRM_OFS_ECHO_QUERY) begin
      w = echo_query_data;
    end else if (a == `FBRM_OFS_IN_DELIM) begin
      w = input_delimiter_value;
    end else if (a == `FBRM_OFS_ERR_COUNT) begin
      w = sent_error_count;
    end else if (a == `FBRM_OFS_POLL_PERIOD) begin
      w = poll_cycle_period;
    end else if (a == `FBRM_OFS_CHECK_TIME) begin
      w = table_check_time;
    end else if (a == `FBRM_OFS_LAST_SCAN) begin
      w = last_scan_time;
    end else if (a == `FBRM_OFS_LAST_DELAY) begin
      w = last_delay_time;
    end
    return w;
  endfunction : int_word

  // Converter for single register formats
  fbrm_conv u_conv (
    .clk_sys_i             (clk_sys_i),
    .sys_rst_i             (sys_rst_i),
    .fmt_i                 (fmt_i),
    .decimal_point_field_i (decimal_point_field_i),
    .db_val_i              (db_val_i),
    .reg_val_i             (reg_val_i),
    .to_reg_o              (to_reg_o),
    .to_db_o               (to_db_o)
  );

  // Table words written only by the database, flags merged on read
  fbrm_tbl_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (mem_wr),
    .wr_idx_i  (db_addr_i[3:0]),
    .wr_data_i (mem_wdata),
    .rd_idx_i  (db_addr_i[3:0]),
    .rd_data_o (tbl_rd)
  );

  // (RULE9) internal set read-only
  always_comb begin
    mem_wr    = db_wr_i && db_addr_i[4];
    mem_wdata = db_wdata_i;
  end

  // Timebase: one pulse every 4 ms
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tick_div <= 18'h00000;
      tick     <= 1'b0;
    end else if (tick_div == 18'(`FBRM_TICK_CYCLES - 1)) begin
      tick_div <= 18'h00000;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 18'h00001;
      tick     <= 1'b0;
    end
  end

  // Slave diagnostic events
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      listen_state_diag     <= 16'h0000;
      echo_query_data       <= 16'h0000;
      input_delimiter_value <= 16'h0000;
    end else begin
      // (RULE10) listen-only bit
      if (ev_listen_i) begin
        listen_state_diag[`FBRM_BIT_LISTEN] <= 1'b1;
      end else if (ev_restart_i) begin
        listen_state_diag[`FBRM_BIT_LISTEN] <= 1'b0;
      end
      // (RULE11) echo and delimiter
      if (ev_echo_i) begin
        echo_query_data <= ev_data_i;
      end
      if (ev_delim_i) begin
        input_delimiter_value <= ev_data_i;
      end
    end
  end

  // Exception counter, cleared on restart unless an exception is counted in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sent_error_count <= 16'h0000;
    end else if (ev_exc_sent_i || wr_refuse_o) begin
      // (RULE12) count sent exceptions
      sent_error_count <= sat_inc(sent_error_count);
    end else if (ev_restart_i) begin
      sent_error_count <= 16'h0000;
    end
  end

  // Task timing in ticks; counters latch on each task boundary
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      poll_cnt          <= 16'h0000;
      scan_cnt          <= 16'h0000;
      delay_cnt         <= 16'h0000;
      poll_cycle_period <= 16'h0000;
      table_check_time  <= 16'h0000;
      last_scan_time    <= 16'h0000;
      last_delay_time   <= 16'h0000;
    end else begin
      // (RULE13) 4 ms tick timings
      if (poll_cycle_i) begin
        poll_cycle_period <= poll_cnt;
        poll_cnt          <= 16'h0000;
      end else if (tick) begin
        poll_cnt <= sat_inc(poll_cnt);
      end
      if (scan_stop_i) begin
        last_scan_time   <= scan_cnt;
        table_check_time <= scan_cnt + delay_cnt;
        delay_cnt        <= 16'h0000;
      end else if (scan_start_i) begin
        scan_cnt <= 16'h0000;
      end else if (tick) begin
        scan_cnt  <= sat_inc(scan_cnt);
        delay_cnt <= sat_inc(delay_cnt);
      end
      if (delay_stop_i) begin
        last_delay_time <= delay_cnt;
      end
    end
  end

  // Per-table hardware flags; event set wins over any clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < 16; k++) begin
        tbl_flags[k] <= 16'h0000;
        idle_cnt[k]  <= 16'h0000;
      end
    end else begin
      for (int k = 0; k < 16; k++) begin
        // (RULE16) slave online timeout
        if (!master_mode_i) begin
          if (ev_access_i && ev_table_i == 4'(k)) begin
            idle_cnt[k]                       <= 16'h0000;
            tbl_flags[k][`FBRM_BIT_ONLINE]    <= 1'b1;
          end else if (idle_cnt[k] >= timeout_ticks_i) begin
            tbl_flags[k][`FBRM_BIT_ONLINE]    <= 1'b0;
          end else if (tick) begin
            idle_cnt[k] <= idle_cnt[k] + 16'h0001;
          end
        end else if (ev_table_i == 4'(k)) begin
          // (RULE22) online on answer
          if (ev_answer_i) begin
            tbl_flags[k][`FBRM_BIT_ONLINE] <= 1'b1;
          end else if (ev_rd_err_i) begin
            tbl_flags[k][`FBRM_BIT_ONLINE] <= 1'b0;
          end
          // (RULE23) (RULE18) read error field
          if (ev_rd_err_i) begin
            tbl_flags[k][`FBRM_RERR_LSB+:4] <= ev_err_code_i;
          end else if (ev_scan_end_i) begin
            tbl_flags[k][`FBRM_RERR_LSB+:4] <= 4'h0;
          end
          // (RULE17) write error field
          if (ev_wr_done_i) begin
            tbl_flags[k][`FBRM_WERR_LSB+:4] <= ev_err_code_i;
          end
          // (RULE20) done set at scan end
          if (ev_scan_end_i) begin
            tbl_flags[k][`FBRM_BIT_DONE] <= 1'b1;
          end
        end
        // (RULE20) (RULE21) single-scan clears done
        if (db_wr_i && db_addr_i[4] && db_addr_i[3:0] == 4'(k) &&
            db_wdata_i[`FBRM_BIT_SINGLE] &&
            !(master_mode_i && ev_scan_end_i && ev_table_i == 4'(k))) begin
          tbl_flags[k][`FBRM_BIT_DONE] <= 1'b0;
        end
      end
    end
  end

  // Master control outputs drawn from control bits of each table
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      poll_en_o     <= 16'h0000;
      write_en_o    <= 16'hFFFF;
      force_write_o <= 16'h0000;
    end else begin
      force_write_o <= 16'h0000;
      if (mem_wr) begin
        // (RULE14) index maps to table
        // (RULE22) (RULE21) polling gates
        poll_en_o[db_addr_i[3:0]] <= master_mode_i &&
          (!db_wdata_i[`FBRM_BIT_NO_CONT] ||
           db_wdata_i[`FBRM_BIT_SINGLE]);
        // (RULE19) write gate and force
        write_en_o[db_addr_i[3:0]] <= !db_wdata_i[`FBRM_BIT_WR_DIS];
        force_write_o[db_addr_i[3:0]] <= master_mode_i &&
          !db_wdata_i[`FBRM_BIT_WR_DIS] &&
          !write_en_o[db_addr_i[3:0]];
      end
    end
  end

  // Slave write refusal with exception 8
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_refuse_o <= 1'b0;
      exc_code_o  <= 4'h0;
    end else begin
      // (RULE15) refuse protected write
      wr_refuse_o <= !master_mode_i && ev_access_i && ev_access_wr_i &&
                     !write_en_o[ev_table_i];
      exc_code_o  <= (!master_mode_i && ev_access_i && ev_access_wr_i &&
                      !write_en_o[ev_table_i]) ? `FBRM_EXC_WRITE : 4'h0;
    end
  end

  // Double precision: low half latched, high half completes the pair
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pair_lo    <= 16'h0000;
      pair_val_o <= 32'h0000_0000;
      pair_err_o <= 1'b0;
    end else if (pair_ld_i) begin
      // (RULE7) even base, coherent
      pair_err_o <= pair_addr_i[0];
      if (!pair_addr_i[0]) begin
        pair_lo <= reg_val_i;
      end else begin
        pair_val_o <= {reg_val_i, pair_lo};
      end
    end
  end

  // Read pipeline: memory word arrives one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_pend     <= 1'b0;
      rd_tbl      <= 1'b0;
      rd_int      <= 16'h0000;
      rd_idx      <= 4'h0;
      db_rvalid_o <= 1'b0;
      db_rdata_o  <= 16'h0000;
    end else begin
      // (RULE8) two sets of sixteen
      rd_pend     <= db_rd_i;
      rd_tbl      <= db_addr_i[4];
      rd_idx      <= db_addr_i[3:0];
      rd_int      <= int_word(db_addr_i);
      db_rvalid_o <= rd_pend;
      if (rd_pend) begin
        // (RULE24) control bits merged with flags
        db_rdata_o <= rd_tbl ? ((tbl_rd & 16'h0015) | tbl_flags[rd_idx])
                             : rd_int;
      end
    end
  end
endmodule : fbrm_register_map

// file: fbrm_register_map_bench.sv
// Self-checking bench for the register map.
// Assumes the far model drives every link event input.
`timescale 1ns/10ps
module fbrm_register_map_bench;
  logic clk_sys_i, sys_rst_i, master_mode_i, db_wr_i, db_rd_i, db_rvalid_o;
  logic [4:0] db_addr_i;
  logic [15:0] db_wdata_i, db_rdata_o, reg_val_i, to_reg_o, ev_data_i;
  logic [31:0] db_val_i, to_db_o, pair_val_o;
  logic [3:0] decimal_point_field_i, ev_table_i, exc_code_o, ev_err_code_i;
  logic pair_ld_i, pair_err_o, wr_refuse_o, ev_access_wr_i;
  logic [15:0] pair_addr_i, timeout_ticks_i, poll_en_o;
  logic [15:0] write_en_o, force_write_o;
  logic ev_echo_i, ev_delim_i, ev_listen_i, ev_restart_i, ev_exc_sent_i;
  logic ev_access_i, ev_scan_end_i, ev_rd_err_i, ev_wr_done_i, ev_answer_i;
  logic poll_cycle_i, scan_start_i, scan_stop_i, delay_stop_i;
  fbrm_pkg::fbrm_fmt_type fmt_i;
  int err_count = 0;
  int num_checks = 0;
  fbrm_far_model far (.clk_sys_i(clk_sys_i), .wr_o(ev_access_wr_i),
    .ev_o({delay_stop_i, scan_stop_i, scan_start_i, poll_cycle_i,
           ev_answer_i, ev_wr_done_i, ev_rd_err_i, ev_scan_end_i,
           ev_access_i, ev_exc_sent_i, ev_restart_i, ev_listen_i,
           ev_delim_i, ev_echo_i}),
    .tbl_o(ev_table_i), .dat_o(ev_data_i), .code_o(ev_err_code_i));
  fbrm_register_map uut (.*);
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    db_wr_i = 1'b1; db_addr_i = a; db_wdata_i = d;
    @(negedge clk_sys_i);
    db_wr_i = 1'b0;
  endtask : wr
  // Bounded wait for the answer strobe
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    int i;
    @(negedge clk_sys_i);
    db_rd_i = 1'b1; db_addr_i = a;
    @(negedge clk_sys_i);
    db_rd_i = 1'b0;
    for (i = 0; i < 4 && db_rvalid_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk("rdata", {16'h0000, e}, {16'h0000, db_rdata_o});
  endtask : rd
  task automatic cv(input fbrm_pkg::fbrm_fmt_type f, input logic [31:0] dv,
    input logic [15:0] rv, input logic [15:0] er, input logic [31:0] ed);
    @(negedge clk_sys_i);
    fmt_i = f; db_val_i = dv; reg_val_i = rv;
    @(negedge clk_sys_i);
    chk("to_reg", {16'h0000, er}, {16'h0000, to_reg_o});
    chk("to_db", ed, to_db_o);
  endtask : cv
  task automatic t_diag;
    rd(5'h10, 16'h0000);
    far.ev(0, 4'h0, 16'hA5C3, 4'h0, 1'b0);
    rd(5'h03, 16'hA5C3);
    far.ev(1, 4'h0, 16'h3A00, 4'h0, 1'b0);
    rd(5'h04, 16'h3A00);
    far.ev(2, 4'h0, 16'h0000, 4'h0, 1'b0);
    rd(5'h02, 16'h0020);
    wr(5'h03, 16'h1234);
    rd(5'h03, 16'hA5C3);
    far.ev(3, 4'h0, 16'h0000, 4'h0, 1'b0);
    rd(5'h02, 16'h0000);
    $display("diag test done");
  endtask : t_diag
  task automatic t_slave;
    wr(5'h15, 16'h0001);
    far.ev(5, 4'h5, 16'h0000, 4'h0, 1'b1);
    chk("refuse", 1, wr_refuse_o);
    chk("exc", 8, exc_code_o);
    far.ev(5, 4'h6, 16'h0000, 4'h0, 1'b1);
    chk("refuse", 0, wr_refuse_o);
    rd(5'h07, 16'h0001);
    far.ev(4, 4'h0, 16'h0000, 4'h0, 1'b0);
    rd(5'h07, 16'h0002);
    rd(5'h15, 16'h0003);
    $display("slave test done");
  endtask : t_slave
  task automatic t_conv;
    decimal_point_field_i = 4'h0;
    cv(fbrm_pkg::FBRM_FMT_SHORT, 32'h0001_8001, 16'h0, 16'h8001, 0);
    cv(fbrm_pkg::FBRM_FMT_SLONG, 32'h1234_8765, 16'h8001, 16'h8765,
       32'hFFFF_8001);
    cv(fbrm_pkg::FBRM_FMT_ULONG, 32'h1234_8765, 16'h8001, 16'h8765,
       32'h0000_8001);
    cv(fbrm_pkg::FBRM_FMT_FLOAT, 32'h0111_7000, 16'hFFFF, 16'hFFFF,
       32'hFFFF_FF00);
    cv(fbrm_pkg::FBRM_FMT_FLOAT, 32'hFEEE_9000, 16'h0002, 16'h0000,
       32'h0000_0200);
    @(negedge clk_sys_i);
    pair_ld_i = 1'b1; reg_val_i = 16'h5678;
    @(negedge clk_sys_i);
    pair_addr_i = 16'h0001; reg_val_i = 16'h1234;
    @(negedge clk_sys_i);
    pair_ld_i = 1'b0;
    chk("pair", 32'h1234_5678, pair_val_o);
    $display("conversion test done");
  endtask : t_conv
  // One-shot poll handshake on table 1
  task automatic t_master;
    @(negedge clk_sys_i);
    master_mode_i = 1'b1;
    wr(5'h10, 16'h0011);
    wr(5'h10, 16'h0010);
    chk("force", 1, force_write_o[0]);
    rd(5'h10, 16'h0010);
    chk("poll_en", 0, poll_en_o[0]);
    wr(5'h10, 16'h0014);
    far.ev(6, 4'h0, 16'h0000, 4'h0, 1'b0);
    rd(5'h10, 16'h001C);
    wr(5'h10, 16'h0010);
    wr(5'h10, 16'h0014);
    rd(5'h10, 16'h0014);
    far.ev(7, 4'h0, 16'h0000, 4'hE, 1'b0);
    rd(5'h10, 16'h0E14);
    far.ev(8, 4'h0, 16'h0000, 4'h2, 1'b0);
    rd(5'h10, 16'h2E14);
    far.ev(9, 4'h0, 16'h0000, 4'h0, 1'b0);
    rd(5'h10, 16'h2E16);
    $display("master test done");
  endtask : t_master
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  initial begin
    sys_rst_i = 1'b1; master_mode_i = 1'b0; db_wr_i = 1'b0; db_rd_i = 1'b0;
    db_addr_i = 5'h00; db_wdata_i = 16'h0000; fmt_i = fbrm_pkg::FBRM_FMT_SHORT;
    db_val_i = 32'h0; reg_val_i = 16'h0; decimal_point_field_i = 4'h0;
    pair_ld_i = 1'b0; pair_addr_i = 16'h0000; timeout_ticks_i = 16'h0002;
    repeat (8) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    t_diag();
    t_slave();
    t_conv();
    t_master();
    wrap_up();
  end
endmodule : fbrm_register_map_bench

// file: fbrm_register_map_sva.sv
// Port checker for the fieldbus register map.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module fbrm_register_map_sva (
  input wire logic                   clk_sys_i,
  input wire logic                   sys_rst_i,
  input wire logic                   master_mode_i,
  input wire logic                   db_rd_i,
  input wire logic                   db_rvalid_o,
  input wire fbrm_pkg::fbrm_fmt_type fmt_i,
  input wire logic [31:0]            db_val_i,
  input wire logic [15:0]            reg_val_i,
  input wire logic [15:0]            to_reg_o,
  input wire logic [31:0]            to_db_o,
  input wire logic                   ev_access_i,
  input wire logic                   ev_access_wr_i,
  input wire logic                   wr_refuse_o,
  input wire logic [3:0]             exc_code_o
);
  // Reset masks every check
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_rd_ans; db_rd_i |-> ##2 db_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_rd_src; db_rvalid_o |-> $past(db_rd_i, 2); endproperty
  a_rd_src: assert property (p_rd_src)
    else $error("answer without read");
  property p_short;
    fmt_i == fbrm_pkg::FBRM_FMT_SHORT |=> to_reg_o == $past(db_val_i[15:0]);
  endproperty
  a_short: assert property (p_short)
    else $error("short value altered");
  property p_sl_out;
    fmt_i == fbrm_pkg::FBRM_FMT_SLONG |=> to_reg_o == $past(db_val_i[15:0]);
  endproperty
  a_sl_out: assert property (p_sl_out)
    else $error("signed long not cut");
  property p_sl_in;
    fmt_i == fbrm_pkg::FBRM_FMT_SLONG |=>
      to_db_o == {{16{$past(reg_val_i[15])}}, $past(reg_val_i)};
  endproperty
  a_sl_in: assert property (p_sl_in)
    else $error("sign not extended");
  property p_ul_in;
    fmt_i == fbrm_pkg::FBRM_FMT_ULONG |=>
      to_db_o == {16'h0000, $past(reg_val_i)};
  endproperty
  a_ul_in: assert property (p_ul_in)
    else $error("upper half not zero");
  property p_exc; wr_refuse_o |-> exc_code_o == 4'h8; endproperty
  a_exc: assert property (p_exc)
    else $error("wrong exception code");
  property p_ref_src;
    wr_refuse_o |-> $past(ev_access_i && ev_access_wr_i && !master_mode_i);
  endproperty
  a_ref_src: assert property (p_ref_src)
    else $error("refusal without slave write");
endmodule : fbrm_register_map_sva
bind fbrm_register_map fbrm_register_map_sva u_sva (.*);

// file: fbrm_tbl_mem.sv
// Sixteen-word store for per-table status and control registers.
// Read data registered; one write port, one read port.
`timescale 1ns/10ps
`include "fbrm_map.svh"
module fbrm_tbl_mem (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wr_en_i,
  input  wire logic [3:0]  wr_idx_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic [3:0]  rd_idx_i,
  output logic      [15:0] rd_data_o
);
  logic [15:0] mem [16];  // One word per table

  // Write port, cleared on reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < 16; k++) begin
        mem[k] <= `FBRM_TBL_RESET;
      end
    end else if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end
endmodule : fbrm_tbl_mem
